// ---- logic/ssl_map.svh ----
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH
`define SSL_A_IFACE 7'h03
`define SSL_A_SAFE 7'h0A
`define SSL_A_PROT 7'h0B
`define SSL_A_CFG_END 7'h13
`define SSL_A_COMMON 7'h40
`define SSL_A_BANKSEL 7'h40
`define SSL_A_ID_END 7'h47
`define SSL_A_USER_END 7'h6F
`define SSL_A_STAT 7'h70
`define SSL_A_STAT_END 7'h73
`define SSL_A_CMD 7'h74
`define SSL_A_CMD_END 7'h77
`define SSL_BANK_CFG0 8'h00
`define SSL_BANK_INFO 8'h02
`define SSL_BANK_USER 8'h0E
`define SSL_BANK_LAST 8'h1F
`define SSL_B_SSI 7
`define SSL_B_EXT 6
`define SSL_B_BIN 5
`define SSL_B_LCEN 6
`define SSL_F_SEED 5:0
`define SSL_B_PROT_EN 0
`define SSL_B_CMDLOCK 1
`define SSL_CMD_PIN 8'h02
`define SSL_CMD_PRESET 8'h03
`define SSL_CFG_RST 8'h00
`define SSL_RAM_WORDS 20
`define SSL_POLY6 6'h03
`define SSL_POLY16 16'h90D9
`define SSL_LEN_STD 6'h0D
`define SSL_LEN_EXT 6'h0E
`define SSL_LEN_FRM_HI 6'h15
`define SSL_LEN_FRM_LO 6'h11
`define SSL_LEN_LC 6'h06
`define SSL_LEN_CRC16 6'h10
`define SSL_LEN_CRC6 6'h06
`define SSL_FRM_HEAD 3'h2
`define SSL_CRC_MASK 48'h1FFF_FFFF_FFFF
`define SSL_LC_MIN 6'h01
`define SSL_LC_MAX 6'h3F
`define SSL_MEAS_RISES 2'h2
`define SSL_TCLK_NUM 4
`define SSL_TCLK_DEN 3
`define SSL_TMO_MIN_TCLK 1
`define SSL_TMO_ADD_TCLK 3
`define SSL_SYNC_LAT 2
`define SSL_TMO_MIN_CYC 16'((`SSL_TMO_MIN_TCLK * `SSL_TCLK_NUM + `SSL_TCLK_DEN - 1) / `SSL_TCLK_DEN)
`define SSL_TMO_ADD_CYC 16'((`SSL_TMO_ADD_TCLK * `SSL_TCLK_NUM) / `SSL_TCLK_DEN - `SSL_SYNC_LAT)
`define SSL_TMO_RST 16'h00FF
`endif

// ---- logic/ssl_pkg.sv ----
`default_nettype none
package ssl_pkg;
    typedef enum logic [1:0] {
        ssl_idle = 2'b00,
        ssl_latch = 2'b01,
        ssl_shift = 2'b10,
        ssl_done = 2'b11
    } ssl_frame_t;

    typedef struct packed {
        ssl_frame_t fsm;
        logic [1:0] rises;
        logic [15:0] meas;
        logic [15:0] tmo_lim;
        logic [15:0] tmo_cnt;
        logic [47:0] sh;
        logic [47:0] mask;
        logic [5:0] cnt;
        logic crc_ph;
        logic slo;
        logic [5:0] lc;
        logic [19:0][7:0] ram;
        logic [7:0] bank;
        logic aux;
        logic preset;
        logic done;
        logic denied;
        logic [7:0] rdata;
    } ssl_state_t;
endpackage
`default_nettype wire

// ---- logic/ssl_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssl_pin_sync #(
    parameter logic RST_LEVEL = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } ssl_sync_t;
    ssl_sync_t s_r;
    ssl_sync_t s_nxt;

    always_comb begin
        s_nxt.meta = i_pin;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= {RST_LEVEL, RST_LEVEL, RST_LEVEL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_level = s_r.sync;
    assign o_rise = s_r.sync & ~s_r.prev;
    assign o_fall = ~s_r.sync & s_r.prev;
endmodule // ssl_pin_sync
`default_nettype wire

// ---- logic/ssl_crc_serial.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssl_crc_serial #(
    parameter int W = 6,
    parameter logic [W-1:0] POLY = '1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_init,
    input wire logic [W-1:0] i_init_value,
    input wire logic i_bit_valid,
    input wire logic i_bit,
    output logic [W-1:0] o_crc
);
    typedef struct packed {
        logic [W-1:0] crc;
    } ssl_crc_t;
    ssl_crc_t s_r;
    ssl_crc_t s_nxt;
    logic fb;

    always_comb begin
        s_nxt = s_r;
        fb = s_r.crc[W-1] ^ i_bit;
        if (i_init) begin
            s_nxt.crc = i_init_value;
        end else if (i_bit_valid) begin
            s_nxt.crc = {s_r.crc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_crc = s_r.crc;
endmodule // ssl_crc_serial
`default_nettype wire

// ---- logic/ssl_serial_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ssl_map.svh"
module ssl_serial_slave (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ma,
    input wire logic [13:0] i_position,
    input wire logic i_high_resolution,
    input wire logic [7:0] i_error_flags,
    input wire logic i_phase_warning,
    input wire logic i_pin_command_enable,
    input wire logic i_preset_command_enable,
    input wire logic i_reg_req,
    input wire logic i_reg_write,
    input wire logic i_reg_bcast,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic o_slo,
    output logic o_aux_output_pin,
    output logic o_preset_pulse,
    output logic o_reg_done,
    output logic o_reg_denied,
    output logic [7:0] o_reg_rdata
);
    ssl_pkg::ssl_state_t s_r;
    ssl_pkg::ssl_state_t s_nxt;
    logic ma_lvl;
    logic ma_rise;
    logic ma_fall;
    logic crc_init;
    logic crc_feed;
    logic crc_bit;
    logic [5:0] crc6;
    logic [15:0] crc16;
    logic [13:0] gray;
    logic [13:0] ssi_pos;
    logic [5:0] lc_n;
    logic [47:0] vec;
    logic [47:0] vmask;
    logic [5:0] len;
    logic [15:0] crc_w;
    logic [5:0] crc_len;
    logic [15:0] lim_new;
    logic [1:0] acc;
    logic ok;
    logic err_low;
    logic warn_low;

    wire logic ssi = s_r.ram[`SSL_A_IFACE][`SSL_B_SSI];
    wire logic ext = s_r.ram[`SSL_A_IFACE][`SSL_B_EXT];
    wire logic bin = s_r.ram[`SSL_A_IFACE][`SSL_B_BIN];
    wire logic lcen = s_r.ram[`SSL_A_SAFE][`SSL_B_LCEN];
    wire logic [5:0] crc_seed = s_r.ram[`SSL_A_SAFE][`SSL_F_SEED];
    wire logic prot = s_r.ram[`SSL_A_PROT][`SSL_B_PROT_EN];
    wire logic lock = s_r.ram[`SSL_A_PROT][`SSL_B_CMDLOCK];

    // returns {read allowed, write allowed}
    function automatic logic [1:0] ssl_access(input logic [6:0] a, input logic [7:0] bank,
                                              input logic pr);
        logic [1:0] r;
        r = 2'b00;
        if (a < `SSL_A_COMMON) begin
            if (bank > `SSL_BANK_LAST) begin
                r = 2'b00;
            end else if (!pr) begin
                r = (bank == `SSL_BANK_CFG0 && a > `SSL_A_CFG_END) ? 2'b00 : 2'b11;
            end else if (bank >= `SSL_BANK_USER) begin
                r = 2'b11;
            end else if (bank >= `SSL_BANK_INFO) begin
                r = 2'b10;
            end
        end else if (a == `SSL_A_BANKSEL) begin
            r = 2'b11;
        end else if (a <= `SSL_A_ID_END) begin
            r = pr ? 2'b10 : 2'b11;
        end else if (a <= `SSL_A_USER_END) begin
            r = 2'b11;
        end else if (a <= `SSL_A_STAT_END) begin
            r = 2'b10;
        end else if (a <= `SSL_A_CMD_END) begin
            r = 2'b01;
        end else begin
            r = pr ? 2'b10 : 2'b11;
        end
        return r;
    endfunction

    ssl_pin_sync #(
        .RST_LEVEL(1'b1)
    ) u_ma_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(i_ma),
        .o_level(ma_lvl),
        .o_rise(ma_rise),
        .o_fall(ma_fall)
    );

    ssl_crc_serial #(
        .W(6),
        .POLY(`SSL_POLY6)
    ) u_crc6 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_init(crc_init),
        .i_init_value(crc_seed),
        .i_bit_valid(crc_feed),
        .i_bit(crc_bit),
        .o_crc(crc6)
    );

    ssl_crc_serial #(
        .W(16),
        .POLY(`SSL_POLY16)
    ) u_crc16 (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_init(crc_init),
        .i_init_value({10'h000, crc_seed}),
        .i_bit_valid(crc_feed),
        .i_bit(crc_bit),
        .o_crc(crc16)
    );

    always_comb begin
        err_low = ~|i_error_flags;
        warn_low = ~i_phase_warning;
        gray = i_position ^ {1'b0, i_position[13:1]};
        ssi_pos = bin ? i_position : gray;
        lc_n = (s_r.lc >= `SSL_LC_MAX) ? `SSL_LC_MIN : s_r.lc + `SSL_LC_MIN;
        vmask = ssi ? 48'h0 : `SSL_CRC_MASK;
        // fields left-aligned so the msb leaves first; the counter trails, so len drops it unless lcen is set
        if (ssi) begin
            if (ext) begin
                vec = {ssi_pos[13:2], err_low, warn_low, lc_n, 28'h0};
                len = `SSL_LEN_EXT + (lcen ? `SSL_LEN_LC : 6'h00);
            end else begin
                vec = {ssi_pos[13:1], 35'h0};
                len = `SSL_LEN_STD;
            end
        end else if (i_high_resolution) begin
            vec = {`SSL_FRM_HEAD, i_position, 2'h0, err_low, warn_low, lc_n, 21'h0};
            len = `SSL_LEN_FRM_HI + (lcen ? `SSL_LEN_LC : 6'h00);
        end else begin
            vec = {`SSL_FRM_HEAD, i_position[13:2], err_low, warn_low, lc_n, 25'h0};
            len = `SSL_LEN_FRM_LO + (lcen ? `SSL_LEN_LC : 6'h00);
        end
        crc_w = lcen ? ~crc16 : {~crc6, 10'h000};
        crc_len = lcen ? `SSL_LEN_CRC16 : `SSL_LEN_CRC6;
        lim_new = s_r.meas + `SSL_TMO_ADD_CYC;
        if (lim_new < `SSL_TMO_MIN_CYC) begin
            lim_new = `SSL_TMO_MIN_CYC;
        end
    end

    always_comb begin
        s_nxt = s_r;
        crc_init = 1'b0;
        crc_feed = 1'b0;
        crc_bit = 1'b0;
        acc = 2'b00;
        ok = 1'b0;
        s_nxt.preset = 1'b0;
        s_nxt.done = i_reg_req;
        s_nxt.denied = 1'b0;

        unique case (s_r.fsm)
            ssl_pkg::ssl_idle: begin
                s_nxt.slo = 1'b1;
                if (ma_fall) begin
                    s_nxt.fsm = ssl_pkg::ssl_latch;
                    s_nxt.meas = 16'h0000;
                    s_nxt.rises = 2'h0;
                    s_nxt.tmo_cnt = 16'h0000;
                end
            end
            ssl_pkg::ssl_latch: begin
                if (ma_rise) begin
                    s_nxt.fsm = ssl_pkg::ssl_shift;
                    s_nxt.slo = vec[47];
                    s_nxt.sh = {vec[46:0], 1'b0};
                    s_nxt.mask = {vmask[46:0], 1'b0};
                    s_nxt.cnt = len - 6'h01;
                    s_nxt.crc_ph = 1'b0;
                    crc_init = 1'b1;
                    if (lcen) begin
                        s_nxt.lc = lc_n;
                    end
                end
            end
            ssl_pkg::ssl_shift: begin
                if (ma_rise) begin
                    if (s_r.cnt != 6'h00) begin
                        s_nxt.slo = s_r.sh[47];
                        crc_feed = s_r.mask[47];
                        crc_bit = s_r.sh[47];
                        s_nxt.sh = {s_r.sh[46:0], 1'b0};
                        s_nxt.mask = {s_r.mask[46:0], 1'b0};
                        s_nxt.cnt = s_r.cnt - 6'h01;
                    end else if (!ssi && !s_r.crc_ph) begin
                        s_nxt.slo = crc_w[15];
                        s_nxt.sh = {crc_w[14:0], 33'h0};
                        s_nxt.mask = 48'h0;
                        s_nxt.cnt = crc_len - 6'h01;
                        s_nxt.crc_ph = 1'b1;
                    end else begin
                        s_nxt.fsm = ssl_pkg::ssl_done;
                        s_nxt.slo = 1'b0;
                    end
                end
            end
            ssl_pkg::ssl_done: begin
                s_nxt.slo = 1'b0;
            end
        endcase

        if (s_r.fsm != ssl_pkg::ssl_idle) begin
            if (s_r.rises != `SSL_MEAS_RISES) begin
                s_nxt.meas = s_r.meas + 16'h0001;
            end
            s_nxt.tmo_cnt = ma_lvl ? s_r.tmo_cnt + 16'h0001 : 16'h0000;
            if (ma_rise && s_r.rises != `SSL_MEAS_RISES) begin
                s_nxt.rises = s_r.rises + 2'h1;
                if (s_r.rises + 2'h1 == `SSL_MEAS_RISES) begin
                    s_nxt.tmo_lim = lim_new;
                end
            end
            // clock held high past the limit ends the frame
            if (ma_lvl && s_r.tmo_cnt >= s_r.tmo_lim) begin
                s_nxt.fsm = ssl_pkg::ssl_idle;
                s_nxt.slo = 1'b1;
            end
        end

        if (i_reg_req) begin
            acc = ssl_access(i_reg_addr, s_r.bank, prot);
            s_nxt.rdata = 8'h00;
            if (i_reg_write) begin
                if (i_reg_addr >= `SSL_A_CMD && i_reg_addr <= `SSL_A_CMD_END) begin
                    ok = acc[0] && !lock;
                    if (ok && i_reg_addr == `SSL_A_CMD) begin
                        if (i_reg_wdata == `SSL_CMD_PIN && i_pin_command_enable) begin
                            s_nxt.aux = !i_reg_bcast;
                        end
                        if (i_reg_wdata == `SSL_CMD_PRESET && i_preset_command_enable) begin
                            s_nxt.preset = 1'b1;
                        end
                    end
                end else begin
                    ok = acc[0];
                    if (ok && i_reg_addr == `SSL_A_BANKSEL) begin
                        s_nxt.bank = i_reg_wdata;
                    end else if (ok && i_reg_addr < `SSL_A_COMMON
                                 && s_r.bank == `SSL_BANK_CFG0) begin
                        s_nxt.ram[i_reg_addr[4:0]] = i_reg_wdata;
                    end
                end
            end else begin
                ok = acc[1];
                if (ok && i_reg_addr == `SSL_A_BANKSEL) begin
                    s_nxt.rdata = s_r.bank;
                end else if (ok && i_reg_addr < `SSL_A_COMMON
                             && s_r.bank == `SSL_BANK_CFG0) begin
                    s_nxt.rdata = s_r.ram[i_reg_addr[4:0]];
                end else if (ok && i_reg_addr == `SSL_A_STAT) begin
                    s_nxt.rdata = i_error_flags;
                end else if (ok && i_reg_addr == `SSL_A_STAT + 7'h01) begin
                    s_nxt.rdata = {7'h00, i_phase_warning};
                end
            end
            s_nxt.denied = !ok;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.fsm <= ssl_pkg::ssl_idle;
            s_r.slo <= 1'b1;
            s_r.tmo_lim <= `SSL_TMO_RST;
            s_r.ram <= {`SSL_RAM_WORDS{`SSL_CFG_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_slo = s_r.slo;
    assign o_aux_output_pin = s_r.aux;
    assign o_preset_pulse = s_r.preset;
    assign o_reg_done = s_r.done;
    assign o_reg_denied = s_r.denied;
    assign o_reg_rdata = s_r.rdata;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    property p_measure;
        ma_rise && s_r.fsm != ssl_pkg::ssl_idle && s_r.rises == 2'h1
            |=> s_r.tmo_lim >= `SSL_TMO_MIN_CYC ##1 $stable(s_r.meas);
    endproperty
    a_measure: assert property (p_measure) else $error("span not frozen at 2nd rise");

    property p_tmo_bound;
        s_r.fsm != ssl_pkg::ssl_idle |-> s_r.tmo_cnt <= s_r.tmo_lim;
    endproperty
    a_tmo_bound: assert property (p_tmo_bound) else $error("timeout overrun");

    property p_register_protection_enable_off;
        i_reg_req && !prot && i_reg_addr < `SSL_A_COMMON && s_r.bank != `SSL_BANK_CFG0
            && s_r.bank <= `SSL_BANK_LAST |=> o_reg_done && !o_reg_denied;
    endproperty
    a_register_protection_enable_off: assert property (p_register_protection_enable_off) else $error("unprotected bank denied");

    property p_cmd_lock;
        i_reg_req && i_reg_write && i_reg_addr == `SSL_A_CMD && lock
            |=> o_reg_denied && $stable(o_aux_output_pin) && !o_preset_pulse;
    endproperty
    a_cmd_lock: assert property (p_cmd_lock) else $error("locked command executed");

    property p_bank_prot;
        i_reg_req && prot && i_reg_addr < `SSL_A_COMMON && s_r.bank < `SSL_BANK_INFO
            |=> o_reg_denied;
    endproperty
    a_bank_prot: assert property (p_bank_prot) else $error("config bank reachable");

    property p_status_ro;
        i_reg_req && i_reg_write && i_reg_addr >= `SSL_A_STAT && i_reg_addr <= `SSL_A_STAT_END
            |=> o_reg_denied;
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write accepted");

    property p_aux_set;
        i_reg_req && i_reg_write && i_reg_addr == `SSL_A_CMD && !lock
            && i_reg_wdata == `SSL_CMD_PIN && i_pin_command_enable
            |=> o_aux_output_pin == !$past(i_reg_bcast);
    endproperty
    a_aux_set: assert property (p_aux_set) else $error("aux pin command wrong");

    property p_lc_nonzero;
        $changed(s_r.lc) |-> s_r.lc != 6'h00;
    endproperty
    a_lc_nonzero: assert property (p_lc_nonzero) else $error("life counter hit zero");

    property p_ssi_std;
        s_r.fsm == ssl_pkg::ssl_latch && ma_rise && ssi && !ext
            |=> s_r.cnt == `SSL_LEN_STD - 6'h01;
    endproperty
    a_ssi_std: assert property (p_ssi_std) else $error("standard frame length wrong");
endmodule // ssl_serial_slave
`default_nettype wire

// ---- testbench/ssl_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ssl_master_model (
    input wire logic i_slo,
    output logic o_ma
);
    initial o_ma = 1'b1;

    // n bits msb-first, then one extra rise to expose the trailing zero
    task automatic read_frame(input int n, output logic [63:0] bits, output logic [1:0] tail);
        bits = '0;
        o_ma = 1'b0;
        #63;
        for (int k = 0; k <= n; k++) begin
            o_ma = 1'b1;
            if (k == n) break;
            // sample mid-period, well clear of the slave's sync latency
            #62;
            bits = {bits[62:0], i_slo};
            o_ma = 1'b0;
            #63;
        end
        #150 tail[1] = i_slo;
        #150 tail[0] = i_slo;
        // clock stands still long past the slave timeout
        #700;
    endtask
endmodule // ssl_master_model
`default_nettype wire

// ---- testbench/test_encoder_serial_slave_protocol.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_encoder_serial_slave_protocol;
    logic i_clock = 1'b0, i_rst = 1'b1, req = 1'b0, wr_en = 1'b0, bc = 1'b0, hr = 1'b0;
    logic warn = 1'b0, pin_en = 1'b0, pre_en = 1'b0, exp_aux = 1'b0;
    logic ma, o_slo, o_aux, o_pre, o_done, o_den;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00, err = 8'h00, o_rd;
    logic [13:0] pos = 14'h0000;
    logic [5:0] lc = 6'h00;
    int seed = 36807, bad_count = 0, samples_checked = 0, cycles = 0;

    ssl_serial_slave u_dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_ma(ma), .i_position(pos),
        .i_high_resolution(hr), .i_error_flags(err), .i_phase_warning(warn),
        .i_pin_command_enable(pin_en), .i_preset_command_enable(pre_en),
        .i_reg_req(req), .i_reg_write(wr_en), .i_reg_bcast(bc), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_slo(o_slo), .o_aux_output_pin(o_aux),
        .o_preset_pulse(o_pre), .o_reg_done(o_done), .o_reg_denied(o_den),
        .o_reg_rdata(o_rd)
    );
    ssl_master_model u_master (.i_slo(o_slo), .o_ma(ma));

    always #5 i_clock = ~i_clock;

    // generous ceiling: about twice the expected run
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 90000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: port value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_frame(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: frame %h, expected %h", $time, got, exp);
        end
    endtask

    // one request, answer looked at in the single cycle that done stands
    task automatic reg_op(input logic w, b, input logic [6:0] a, input logic [7:0] d,
                          input logic den, input logic [7:0] rd, input logic pre);
        @(posedge i_clock);
        #1;
        {req, wr_en, bc, addr, wdata} = {1'b1, w, b, a, d};
        @(posedge i_clock);
        #1;
        req = 1'b0;
        chk_val({o_done, o_den, o_rd, o_pre, o_aux}, {1'b1, den, rd, pre, exp_aux});
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic den);
        reg_op(1'b1, 1'b0, a, d, den, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [6:0] a, input logic den, input logic [7:0] v);
        reg_op(1'b0, 1'b0, a, 8'h00, den, v, 1'b0);
    endtask

    function automatic logic [63:0] exp_frame(input logic [7:0] ifc, saf, output int n);
        logic [47:0] d;
        logic [15:0] p, c, mask;
        logic ssi, ext, fb;
        int w, cw;
        ssi = ifc[7];
        ext = ssi && ifc[6];
        w = ssi ? (ext ? 12 : 13) : (hr ? 16 : 12);
        p = (!ssi && hr) ? {pos, 2'b00} : (ssi && !ext) ? 16'(pos[13:1]) : 16'(pos[13:2]);
        if (ssi && !ifc[5]) p = p ^ (p >> 1);
        d = 48'(p);
        n = w;
        if (!ssi || ext) begin
            d = {d[45:0], ~|err, ~warn};
            n += 2;
            if (saf[6]) begin
                d = {d[41:0], lc};
                n += 6;
            end
        end
        if (ssi) return 64'(d);
        cw = saf[6] ? 16 : 6;
        mask = 16'((17'h1 << cw) - 17'h1);
        c = 16'(saf[5:0]);
        for (int i = n - 1; i >= 0; i--) begin
            fb = c[cw - 1] ^ d[i];
            c = (c << 1) & mask;
            if (fb) c ^= saf[6] ? 16'h90D9 : 16'h0003;
        end
        exp_frame = ((64'(d) | (64'h2 << n)) << cw) | 64'(~c & mask);
        n += 3 + cw;
    endfunction

    task automatic frame(input logic [7:0] ifc, saf);
        logic [63:0] got, exp;
        logic [1:0] tail;
        int n;
        wr(7'h03, ifc, 1'b0);
        wr(7'h0A, saf, 1'b0);
        {pos, err, warn, hr} = 24'($random(seed));
        // half the frames error-free so both levels of the error bit show
        err = err & {8{hr}};
        if (saf[6]) lc = (lc == 6'h3F) ? 6'h01 : lc + 6'h01;
        exp = exp_frame(ifc, saf, n);
        u_master.read_frame(n, got, tail);
        chk_frame(got, exp);
        chk_val(12'(tail), 12'h001);
    endtask

    initial begin
        repeat (10) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        err = 8'($random(seed));
        wr(7'h03, 8'hA5, 1'b0);
        rd(7'h03, 1'b0, 8'hA5);
        rd(7'h70, 1'b0, err);
        warn = 1'b1;
        rd(7'h71, 1'b0, 8'h01);
        wr(7'h70, 8'h55, 1'b1);
        rd(7'h74, 1'b1, 8'h00);
        rd(7'h14, 1'b1, 8'h00);
        for (int i = 0; i < 16; i++) begin
            {pin_en, pre_en} = 2'($random(seed));
            if (i[1:0] == 2'h2 && pin_en) exp_aux = !i[2];
            reg_op(1'b1, i[2], 7'h74, 8'(i[1:0]), 1'b0, 8'h00, i[1:0] == 2'h3 && pre_en);
        end
        pin_en = 1'b1;
        exp_aux = 1'b0;
        reg_op(1'b1, 1'b1, 7'h74, 8'h02, 1'b0, 8'h00, 1'b0);
        wr(7'h0B, 8'h02, 1'b0);
        wr(7'h74, 8'h02, 1'b1);
        wr(7'h0B, 8'h00, 1'b0);
        frame(8'h00, 8'h00);
        frame(8'h00, 8'h3F);
        for (int i = 0; i < 90; i++)
            frame(8'($random(seed)) & 8'hE0,
                  8'($random(seed)) | (i < 70 ? 8'h40 : 8'h00));
        wr(7'h40, 8'h02, 1'b0);
        wr(7'h10, 8'h33, 1'b0);
        wr(7'h40, 8'h00, 1'b0);
        wr(7'h0B, 8'h01, 1'b0);
        rd(7'h03, 1'b1, 8'h00);
        wr(7'h40, 8'h02, 1'b0);
        rd(7'h40, 1'b0, 8'h02);
        rd(7'h10, 1'b0, 8'h00);
        wr(7'h10, 8'h33, 1'b1);
        wr(7'h41, 8'h33, 1'b1);
        wr(7'h48, 8'h33, 1'b0);
        wr(7'h40, 8'h0E, 1'b0);
        wr(7'h10, 8'h33, 1'b0);
        wr(7'h40, 8'h01, 1'b0);
        rd(7'h00, 1'b1, 8'h00);
        @(posedge i_clock);
        #1;
        i_rst = 1'b1;
        repeat (3) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        rd(7'h0B, 1'b0, 8'h00);
        rd(7'h03, 1'b0, 8'h00);
        end_sim();
    end
endmodule // test_encoder_serial_slave_protocol
`default_nettype wire
